// ===== rtl/ucs_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module ucs_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic push;
   logic pop;

   assign in_ready_o = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr_r != rd_ptr_r;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr_r[AW-1:0]];

   always_ff @(posedge sys_clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule

// ===== rtl/ucs_pkg.sv
// package for the serial control register block: offsets, fields, types, timing
package ucs_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] UART_CONTROL_ADDR = 8'h98;
   localparam logic [7:0] UART_CONTROL_RST = 8'h00;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_MODE_HIGH = 7;
   localparam int BIT_MODE_LOW = 6;
   localparam int BIT_MULTIPROC = 5;
   localparam int BIT_RX_ENABLE = 4;
   localparam int BIT_TX_NINTH = 3;
   localparam int BIT_RX_NINTH = 2;
   localparam int BIT_TX_DONE = 1;
   localparam int BIT_RX_DONE = 0;

   // ---------------------------------------------------------------
   // timing and buffering
   // ---------------------------------------------------------------
   localparam logic [7:0] BIT_TICKS_DEFAULT = 8'h0F;
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0]
   {
      UCS_MODE_SHIFT = 2'b00,
      UCS_MODE_UART8 = 2'b01,
      UCS_MODE_UART9A = 2'b10,
      UCS_MODE_UART9B = 2'b11
   } ucs_mode_t;

   typedef enum logic [1:0]
   {
      UCS_IDLE = 2'b00,
      UCS_START = 2'b01,
      UCS_DATA = 2'b11,
      UCS_STOP = 2'b10
   } ucs_state_t;

   // cpu side access to the special function register space
   typedef struct packed
   {
      logic [7:0] addr;
      logic wr;
      logic bit_wr;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } ucs_sfr_req_t;

   // one received word heading to the cpu
   typedef struct packed
   {
      logic ninth;
      logic [7:0] data;
   } ucs_rx_word_t;

endpackage

// ===== rtl/ucs_uart_control.sv
// serial port control register with transmitter, receiver and receive fifo
// Operation
// - mode bits select shift register, 8-bit uart, or two 9-bit uart modes
// - bit 7 maps to high mode bit when select clear, framing error when set
// - transmit done set after eighth bit in mode 0, else at stop bit start
// - reset clears control register; every bit settable by bit writes
// - with checking enabled, a missing stop bit sets framing error
// - framing error stays until software or reset clears it
// - with checking enabled, receive done rises at stop bit only when the stop bit is high
// - multiproc mode raises receive done only for own or broadcast address, except in mode 0
`timescale 1ns/1ps
module ucs_uart_control
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // special function register access
   input wire ucs_pkg::ucs_sfr_req_t sfr_req_i,
   output logic [7:0] sfr_rdata_o,
   // transmit data and framing check select
   input wire logic tx_start_i,
   input wire logic [7:0] tx_data_i,
   input wire logic bit7_select_i,
   input wire logic [7:0] own_addr_i,
   input wire logic [7:0] addr_mask_i,
   // received words
   output logic rx_valid_o,
   output ucs_pkg::ucs_rx_word_t rx_word_o,
   input wire logic rx_ready_i,
   // serial line
   input wire logic rxd_i,
   output logic txd_o,
   output logic shift_clk_o
);
   logic mode_select_high_r, mode_select_low_r, multiproc_enable_r, rx_enable_r;
   logic tx_ninth_bit_r, rx_ninth_bit_r, transmit_done_flag_r, receive_done_flag_r;
   logic framing_error_flag_r;
   ucs_pkg::ucs_mode_t mode;
   logic sel, wr_hit, bit_hit;
   logic [7:0] wmask, wval;
   logic tx_done_ev, rx_done_ev, fe_ev, rx_ninth_ev, rx_ninth_val;
   ucs_pkg::ucs_state_t tx_state_r, rx_state_r;
   logic [7:0] tx_tick_r, rx_tick_r;
   logic [3:0] tx_cnt_r, rx_cnt_r;
   logic [8:0] tx_shift_r, rx_shift_r;
   logic [3:0] nbits;
   logic fifo_in_ready, rx_push, addr_ok;
   logic [7:0] given_addr, bcast_addr;

   assign mode = ucs_pkg::ucs_mode_t'({mode_select_high_r, mode_select_low_r});
   assign nbits = mode[1] ? 4'h9 : 4'h8;
   assign sel = sfr_req_i.addr == ucs_pkg::UART_CONTROL_ADDR;
   assign wr_hit = sel && sfr_req_i.wr;
   assign bit_hit = sel && sfr_req_i.bit_wr;

   // ---------------------------------------------------------------
   // write decode: byte writes or single bit writes
   // ---------------------------------------------------------------
   always_comb
   begin
      wmask = 8'h00;
      wval = sfr_req_i.wdata;
      if (wr_hit)
      begin
         wmask = 8'hFF;
      end
      else if (bit_hit)
      begin
         wmask = 8'h01 << sfr_req_i.bit_idx;
         wval = {8{sfr_req_i.wdata[0]}};
      end
   end

   // ---------------------------------------------------------------
   // control bits
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         mode_select_high_r <= 1'b0;
         mode_select_low_r <= 1'b0;
         multiproc_enable_r <= 1'b0;
         rx_enable_r <= 1'b0;
         tx_ninth_bit_r <= 1'b0;
      end
      else
      begin
         if (wmask[ucs_pkg::BIT_MODE_HIGH] && !bit7_select_i)
         begin
            mode_select_high_r <= wval[ucs_pkg::BIT_MODE_HIGH];
         end
         if (wmask[ucs_pkg::BIT_MODE_LOW])
         begin
            mode_select_low_r <= wval[ucs_pkg::BIT_MODE_LOW];
         end
         if (wmask[ucs_pkg::BIT_MULTIPROC])
         begin
            multiproc_enable_r <= wval[ucs_pkg::BIT_MULTIPROC];
         end
         if (wmask[ucs_pkg::BIT_RX_ENABLE])
         begin
            rx_enable_r <= wval[ucs_pkg::BIT_RX_ENABLE];
         end
         if (wmask[ucs_pkg::BIT_TX_NINTH])
         begin
            tx_ninth_bit_r <= wval[ucs_pkg::BIT_TX_NINTH];
         end
      end
   end

   // ---------------------------------------------------------------
   // hardware set flags; a set in the same cycle beats a software clear
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         transmit_done_flag_r <= 1'b0;
         receive_done_flag_r <= 1'b0;
         framing_error_flag_r <= 1'b0;
         rx_ninth_bit_r <= 1'b0;
      end
      else
      begin
         if (tx_done_ev)
         begin
            transmit_done_flag_r <= 1'b1;
         end
         else if (wmask[ucs_pkg::BIT_TX_DONE])
         begin
            transmit_done_flag_r <= wval[ucs_pkg::BIT_TX_DONE];
         end
         if (rx_done_ev)
         begin
            receive_done_flag_r <= 1'b1;
         end
         else if (wmask[ucs_pkg::BIT_RX_DONE])
         begin
            receive_done_flag_r <= wval[ucs_pkg::BIT_RX_DONE];
         end
         if (fe_ev)
         begin
            framing_error_flag_r <= 1'b1;
         end
         else if (wmask[ucs_pkg::BIT_MODE_HIGH] && bit7_select_i)
         begin
            framing_error_flag_r <= wval[ucs_pkg::BIT_MODE_HIGH];
         end
         if (rx_ninth_ev)
         begin
            rx_ninth_bit_r <= rx_ninth_val;
         end
         else if (wmask[ucs_pkg::BIT_RX_NINTH])
         begin
            rx_ninth_bit_r <= wval[ucs_pkg::BIT_RX_NINTH];
         end
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         sfr_rdata_o <= ucs_pkg::UART_CONTROL_RST;
      end
      else
      begin
         sfr_rdata_o <= sel ? {bit7_select_i ? framing_error_flag_r : mode_select_high_r,
            mode_select_low_r, multiproc_enable_r, rx_enable_r, tx_ninth_bit_r,
            rx_ninth_bit_r, transmit_done_flag_r, receive_done_flag_r} : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // transmitter: start, data (8 or 9), stop; mode 0 shifts 8 bits, no framing
   // ---------------------------------------------------------------
   assign tx_done_ev = (tx_state_r == ucs_pkg::UCS_DATA) && (tx_tick_r == 8'h00)
      && (tx_cnt_r == nbits - 4'h1);
   assign shift_clk_o = (mode == ucs_pkg::UCS_MODE_SHIFT) && tx_tick_r[3];

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_state_r <= ucs_pkg::UCS_IDLE;
         tx_tick_r <= 8'h00;
         tx_cnt_r <= 4'h0;
         tx_shift_r <= 9'h000;
         txd_o <= 1'b1;
      end
      else
      begin
         tx_tick_r <= (tx_tick_r == 8'h00) ? ucs_pkg::BIT_TICKS_DEFAULT : tx_tick_r - 8'h01;
         unique case (tx_state_r)
            ucs_pkg::UCS_IDLE:
            begin
               txd_o <= 1'b1;
               if (tx_start_i)
               begin
                  tx_shift_r <= {tx_ninth_bit_r, tx_data_i};
                  tx_tick_r <= ucs_pkg::BIT_TICKS_DEFAULT;
                  tx_cnt_r <= 4'h0;
                  if (mode == ucs_pkg::UCS_MODE_SHIFT)
                  begin
                     txd_o <= tx_data_i[0];
                     tx_shift_r <= {1'b0, 1'b0, tx_data_i[7:1]};
                     tx_state_r <= ucs_pkg::UCS_DATA;
                  end
                  else
                  begin
                     txd_o <= 1'b0;
                     tx_state_r <= ucs_pkg::UCS_START;
                  end
               end
            end
            ucs_pkg::UCS_START:
            begin
               if (tx_tick_r == 8'h00)
               begin
                  txd_o <= tx_shift_r[0];
                  tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                  tx_state_r <= ucs_pkg::UCS_DATA;
               end
            end
            ucs_pkg::UCS_DATA:
            begin
               if (tx_tick_r == 8'h00)
               begin
                  if (tx_cnt_r == nbits - 4'h1)
                  begin
                     txd_o <= 1'b1;
                     tx_state_r <= (mode == ucs_pkg::UCS_MODE_SHIFT) ? ucs_pkg::UCS_IDLE
                        : ucs_pkg::UCS_STOP;
                  end
                  else
                  begin
                     txd_o <= tx_shift_r[0];
                     tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                     tx_cnt_r <= tx_cnt_r + 4'h1;
                  end
               end
            end
            ucs_pkg::UCS_STOP:
            begin
               if (tx_tick_r == 8'h00)
               begin
                  tx_state_r <= ucs_pkg::UCS_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // receiver
   // ---------------------------------------------------------------
   assign given_addr = own_addr_i & addr_mask_i;
   assign bcast_addr = own_addr_i | addr_mask_i;
   // the filter checks the data byte alone, with no address marker; zeros of the broadcast byte are don't care
   assign addr_ok = !multiproc_enable_r || (mode == ucs_pkg::UCS_MODE_SHIFT)
      || (((rx_shift_r[7:0] & addr_mask_i) == given_addr)
      || ((rx_shift_r[7:0] & bcast_addr) == bcast_addr));
   logic rx_end;
   assign rx_end = (rx_tick_r == 8'h00);
   assign rx_done_ev = rx_push && fifo_in_ready;
   assign rx_ninth_ev = rx_done_ev && (mode != ucs_pkg::UCS_MODE_SHIFT);
   assign rx_ninth_val = mode[1] ? rx_shift_r[8] : rxd_i;
   assign fe_ev = bit7_select_i && (rx_state_r == ucs_pkg::UCS_STOP) && rx_end
      && !rxd_i;
   // receive done at the stop bit; mode 0 right after bit eight
   assign rx_push = rx_end && addr_ok && !receive_done_flag_r
      && ((rx_state_r == ucs_pkg::UCS_STOP && (rxd_i || !bit7_select_i))
      || (rx_state_r == ucs_pkg::UCS_DATA && mode == ucs_pkg::UCS_MODE_SHIFT
      && rx_cnt_r == 4'h7));

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         rx_state_r <= ucs_pkg::UCS_IDLE;
         rx_tick_r <= 8'h00;
         rx_cnt_r <= 4'h0;
         rx_shift_r <= 9'h000;
      end
      else
      begin
         rx_tick_r <= rx_end ? ucs_pkg::BIT_TICKS_DEFAULT : rx_tick_r - 8'h01;
         unique case (rx_state_r)
            ucs_pkg::UCS_IDLE:
            begin
               rx_cnt_r <= 4'h0;
               if (rx_enable_r && (mode == ucs_pkg::UCS_MODE_SHIFT || !rxd_i))
               begin
                  // uart modes wait half a bit first, so every later sample lands mid-bit, clear of edges; mode 0 waits a full bit
                  rx_tick_r <= (mode == ucs_pkg::UCS_MODE_SHIFT) ? ucs_pkg::BIT_TICKS_DEFAULT
                     : ucs_pkg::BIT_TICKS_DEFAULT >> 1;
                  rx_state_r <= (mode == ucs_pkg::UCS_MODE_SHIFT) ? ucs_pkg::UCS_DATA
                     : ucs_pkg::UCS_START;
               end
            end
            ucs_pkg::UCS_START:
            begin
               if (rx_end)
               begin
                  rx_state_r <= ucs_pkg::UCS_DATA;
               end
            end
            ucs_pkg::UCS_DATA:
            begin
               if (rx_end)
               begin
                  rx_shift_r <= mode[1] ? {rxd_i, rx_shift_r[8:1]}
                     : {1'b0, rxd_i, rx_shift_r[7:1]};
                  rx_cnt_r <= rx_cnt_r + 4'h1;
                  if (rx_cnt_r == nbits - 4'h1)
                  begin
                     rx_state_r <= (mode == ucs_pkg::UCS_MODE_SHIFT) ? ucs_pkg::UCS_IDLE
                        : ucs_pkg::UCS_STOP;
                  end
               end
            end
            ucs_pkg::UCS_STOP:
            begin
               if (rx_end)
               begin
                  rx_state_r <= ucs_pkg::UCS_IDLE;
               end
            end
         endcase
      end
   end

   // mode 0 samples the last bit in the same edge; a full fifo drops the frame
   ucs_fifo #(
      .WIDTH(ucs_pkg::FIFO_WIDTH),
      .DEPTH(ucs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(rx_push),
      .in_data_i({rx_ninth_val, (mode == ucs_pkg::UCS_MODE_SHIFT)
         ? {rxd_i, rx_shift_r[7:1]} : rx_shift_r[7:0]}),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(rx_valid_o),
      .out_data_o(rx_word_o),
      .out_ready_i(rx_ready_i)
   );
endmodule

// ===== tb/tb_ucs_uart_control.sv
// self-checking bench for the serial control register block
`timescale 1ns/1ps
module tb_ucs_uart_control;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   ucs_pkg::ucs_sfr_req_t req = '{addr: ucs_pkg::UART_CONTROL_ADDR, default: '0};
   logic [7:0] rdata;
   logic tx_start = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic b7sel = 1'b0;
   logic [7:0] own_addr = 8'h00;
   logic [7:0] mask = 8'h00;
   logic rx_valid;
   ucs_pkg::ucs_rx_word_t rx_word;
   logic rx_ready = 1'b0;
   logic rxd;
   logic txd;
   logic sclk;
   int err_total = 0;
   int checked = 0;
   int n;
   int i;
   logic [7:0] d;
   // written value beside the value read back
   logic [15:0] rows [7] = '{16'hffff, 16'ha5a5, 16'h5a5a, 16'h4040, 16'h8080, 16'hc0c0,
      16'h0000};

   initial
   begin
      forever #20 sys_clk_i = ~sys_clk_i;
   end

   ucs_uart_control dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sfr_req_i(req),
      .sfr_rdata_o(rdata), .tx_start_i(tx_start), .tx_data_i(tx_data),
      .bit7_select_i(b7sel), .own_addr_i(own_addr), .addr_mask_i(mask),
      .rx_valid_o(rx_valid), .rx_word_o(rx_word), .rx_ready_i(rx_ready), .rxd_i(rxd),
      .txd_o(txd), .shift_clk_o(sclk));
   ucs_remote_node u_node (.sys_clk_i(sys_clk_i), .line_i(txd), .line_o(rxd));

   // ----
   // tasks
   // ----
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] v);
      @(negedge sys_clk_i);
      req.wr = 1'b1;
      req.wdata = v;
      @(negedge sys_clk_i);
      req.wr = 1'b0;
   endtask
   task automatic bw(input logic [2:0] idx, input logic v);
      @(negedge sys_clk_i);
      req.bit_wr = 1'b1;
      req.bit_idx = idx;
      req.wdata = {7'h00, v};
      @(negedge sys_clk_i);
      req.bit_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge sys_clk_i);
      req.addr = a;
      repeat (2) @(negedge sys_clk_i);
      v = rdata;
      req.addr = ucs_pkg::UART_CONTROL_ADDR;
   endtask
   task automatic pop;
      @(negedge sys_clk_i);
      rx_ready = 1'b1;
      @(negedge sys_clk_i);
      rx_ready = 1'b0;
   endtask
   // counts falling edges until the done flag shows in the read data
   task automatic tx(input logic [7:0] v);
      @(negedge sys_clk_i);
      tx_data = v;
      tx_start = 1'b1;
      @(negedge sys_clk_i);
      tx_start = 1'b0;
      n = 0;
      while (rdata[1] !== 1'b1)
      begin
         @(negedge sys_clk_i);
         n++;
         if (n > 600)
         begin
            err_total++;
            print_verdict();
         end
      end
   endtask
   task automatic rx_one(input logic [8:0] w, input logic stop);
      u_node.send(w, 8, stop);
      repeat (20) @(negedge sys_clk_i);
      bw(3'h0, 1'b0);
   endtask

   // ----
   // main sequence
   // ----
   initial
   begin
      repeat (3) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("reset value", d, 9'h000);
      foreach (rows[k])
      begin
         wr(rows[k][15:8]);
         rd(ucs_pkg::UART_CONTROL_ADDR, d);
         chk("byte rw", d, rows[k][7:0]);
      end
      for (i = 0; i < 8; i++)
      begin
         bw(i[2:0], 1'b1);
         rd(ucs_pkg::UART_CONTROL_ADDR, d);
         chk("bit set", d, 9'h001 << i);
         bw(i[2:0], 1'b0);
      end
      rd(8'h99, d);
      chk("unmapped", d, 9'h000);
      // mode 1 then mode 2 transmit: done at stop start, ninth bit from the register
      wr(8'h50);
      tx(8'ha6);
      chk("tx done mode1", n, 145);
      repeat (40) @(negedge sys_clk_i);
      chk("tx frame mode1", u_node.got, 9'h1a6);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("tx done kept", d[1], 1'b1);
      wr(8'h80);
      tx(8'ha6);
      chk("tx done mode2", n, 161);
      repeat (56) @(negedge sys_clk_i);
      chk("tx frame mode2", u_node.got, 9'h0a6);
      bw(3'h1, 1'b0);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("tx done clear", d[1], 1'b0);
      // mid-run reset also flushes the frame that the bit walk started in shift mode
      @(negedge sys_clk_i);
      sys_rst_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("reset again", d, 9'h000);
      chk("fifo flushed", rx_valid, 1'b0);
      tx(8'h3c);
      chk("tx done mode0", n, 129);
      // fill the receive fifo until it refuses, then drain it
      wr(8'h50);
      chk("shift clock quiet", sclk, 1'b0);
      for (i = 0; i < 17; i++)
         rx_one({1'b0, i[7:0]}, 1'b1);
      n = 0;
      while (rx_valid === 1'b1 && n < 20)
      begin
         chk("fifo word", rx_word, {1'b1, n[7:0]});
         pop();
         n++;
      end
      chk("fifo depth", n, 16);
      // bad stop bit; the error survives a good frame
      b7sel = 1'b1;
      rx_one(9'h055, 1'b0);
      repeat (200) @(negedge sys_clk_i);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("framing set", d[7], 1'b1);
      // the line held low after the bad stop starts a stray frame that sets receive done
      bw(3'h0, 1'b0);
      rx_one(9'h055, 1'b1);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("framing kept", d[7], 1'b1);
      bw(3'h7, 1'b0);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("framing clear", d[7], 1'b0);
      b7sel = 1'b0;
      repeat (4) pop();
      // address frames in mode 2 with multiprocessor filtering
      wr(8'hb0);
      own_addr = 8'h56;
      mask = 8'hfc;
      u_node.send(9'h111, 9, 1'b1);
      repeat (20) @(negedge sys_clk_i);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("foreign address", d[0], 1'b0);
      u_node.send(9'h157, 9, 1'b1);
      repeat (20) @(negedge sys_clk_i);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("given address", d, 9'h0b5);
      chk("ninth stored", rx_word, 9'h157);
      bw(3'h0, 1'b0);
      u_node.send(9'h1fd, 9, 1'b1);
      repeat (20) @(negedge sys_clk_i);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("broadcast bit clear", d[0], 1'b0);
      u_node.send(9'h1ff, 9, 1'b1);
      repeat (20) @(negedge sys_clk_i);
      rd(ucs_pkg::UART_CONTROL_ADDR, d);
      chk("broadcast", d[0], 1'b1);
      print_verdict();
   end
endmodule

// ===== tb/ucs_remote_node.sv
// remote serial node: sends frames to the block and captures its output
`timescale 1ns/1ps
module ucs_remote_node
(
   // clock
   input wire logic sys_clk_i,
   // serial line
   input wire logic line_i,
   output logic line_o
);
   logic [8:0] got = 9'h000;
   int got_cnt = 0;

   initial
   begin
      line_o = 1'b1;
   end

   // 16 clocks a bit; line rests high between frames
   task automatic send(input logic [8:0] w, input int nb, input logic stop);
      int i;
      @(posedge sys_clk_i);
      line_o <= 1'b0;
      repeat (16) @(posedge sys_clk_i);
      for (i = 0; i < nb; i++)
      begin
         line_o <= w[i];
         repeat (16) @(posedge sys_clk_i);
      end
      line_o <= stop;
      repeat (16) @(posedge sys_clk_i);
      line_o <= 1'b1;
   endtask

   // samples mid-bit; the ninth sample is the ninth bit or the stop bit
   initial
   begin : capture
      int i;
      forever
      begin
         @(negedge line_i);
         repeat (8) @(posedge sys_clk_i);
         for (i = 0; i < 9; i++)
         begin
            repeat (16) @(posedge sys_clk_i);
            got[i] = line_i;
         end
         got_cnt++;
      end
   end
endmodule

// ===== tb/ucs_uart_control_checker.sv
// port assertions for the serial control register block
`timescale 1ns/1ps
module ucs_uart_control_checker
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // register access
   input wire ucs_pkg::ucs_sfr_req_t sfr_req_i,
   input wire logic [7:0] sfr_rdata_o,
   // transmit and address setup
   input wire logic tx_start_i,
   input wire logic [7:0] tx_data_i,
   input wire logic bit7_select_i,
   input wire logic [7:0] own_addr_i,
   input wire logic [7:0] addr_mask_i,
   // received words
   input wire logic rx_valid_o,
   input wire ucs_pkg::ucs_rx_word_t rx_word_o,
   input wire logic rx_ready_i,
   // serial line
   input wire logic rxd_i,
   input wire logic txd_o,
   input wire logic shift_clk_o
);
   logic sel;
   logic idle;
   assign sel = sfr_req_i.addr == ucs_pkg::UART_CONTROL_ADDR;
   assign idle = sel && !sfr_req_i.wr && !sfr_req_i.bit_wr;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_unsel_zero;
      !sel |=> sfr_rdata_o == 8'h00;
   endproperty
   a_unsel_zero: assert property (p_unsel_zero)
      else $error("read data not zero for other address");
   property p_reset_clear;
      $past(sys_rst_i) && idle |-> txd_o ##1 sfr_rdata_o == 8'h00;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("state after reset not cleared");
   property p_byte_rw;
      sel && sfr_req_i.wr ##1 idle |=> sfr_rdata_o[6:3] == $past(sfr_req_i.wdata[6:3], 2);
   endproperty
   a_byte_rw: assert property (p_byte_rw)
      else $error("byte write not read back");
   property p_bit_rw;
      sel && sfr_req_i.bit_wr && sfr_req_i.bit_idx inside {[3:7]} && !bit7_select_i
      ##1 idle && !bit7_select_i
      |=> sfr_rdata_o[$past(sfr_req_i.bit_idx, 2)] == $past(sfr_req_i.wdata[0], 2);
   endproperty
   a_bit_rw: assert property (p_bit_rw)
      else $error("bit write not read back");
   property p_tx_sticky;
      $past(idle) && idle && sfr_rdata_o[1] |=> sfr_rdata_o[1];
   endproperty
   a_tx_sticky: assert property (p_tx_sticky)
      else $error("transmit done dropped without write");
   property p_rx_sticky;
      $past(idle) && idle && sfr_rdata_o[0] |=> sfr_rdata_o[0];
   endproperty
   a_rx_sticky: assert property (p_rx_sticky)
      else $error("receive done dropped without write");
   property p_fe_sticky;
      $past(idle && bit7_select_i) && idle && bit7_select_i && sfr_rdata_o[7]
      |=> sfr_rdata_o[7];
   endproperty
   a_fe_sticky: assert property (p_fe_sticky)
      else $error("framing error dropped without write");
   property p_fifo_hold;
      rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_word_o);
   endproperty
   a_fifo_hold: assert property (p_fifo_hold)
      else $error("received word changed before pop");
endmodule

bind ucs_uart_control ucs_uart_control_checker u_chk (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
   .tx_start_i(tx_start_i), .tx_data_i(tx_data_i), .bit7_select_i(bit7_select_i),
   .own_addr_i(own_addr_i), .addr_mask_i(addr_mask_i), .rx_valid_o(rx_valid_o),
   .rx_word_o(rx_word_o), .rx_ready_i(rx_ready_i), .rxd_i(rxd_i), .txd_o(txd_o),
   .shift_clk_o(shift_clk_o));
